// ==== hw/trim_bank_defines.svh ====
// offsets, field positions, reset values and counts of the core trim bank
`ifndef TRIM_BANK_DEFINES_SVH
`define TRIM_BANK_DEFINES_SVH

// register byte offsets on the register port
`define OFS_CORE_B_SINGLE_IN1_TIMING_TRIM 12'h315
`define OFS_CORE_A_SINGLE_IN2_TIMING_TRIM 12'h31a
`define OFS_CORE_B_SINGLE_IN2_TIMING_TRIM 12'h31b
`define OFS_CORE_A_DUAL_IN1_OFFSET_TRIM   12'h344
`define OFS_CORE_A_DUAL_IN2_OFFSET_TRIM   12'h346
`define OFS_CORE_A_SINGLE_IN1_OFFSET_TRIM 12'h348

// slot index of each register inside the bank and in the fuse memory
`define IDX_B_SINGLE_IN1_TIMING 3'h0
`define IDX_A_SINGLE_IN2_TIMING 3'h1
`define IDX_B_SINGLE_IN2_TIMING 3'h2
`define IDX_A_DUAL_IN1_OFFSET   3'h3
`define IDX_A_DUAL_IN2_OFFSET   3'h4
`define IDX_A_SINGLE_IN1_OFFSET 3'h5
`define TRIM_LAST_IDX           3'h5

// field layout
`define TIMING_TRIM_MSB   7
`define OFFSET_TRIM_MSB   11
`define OFFSET_RSVD_MSB   15
`define OFFSET_RSVD_LSB   12
`define TIMING_TRIM_MASK  16'h00ff
`define OFFSET_REG_MASK   16'hffff

// reset values before the fuse load
`define TIMING_TRIM_RESET 16'h0000
`define OFFSET_TRIM_RESET 16'h0000

`endif

// ==== hw/trim_bank_pkg.sv ====
// types shared by the core trim bank
package trim_bank_pkg;

	// fuse load sequencer, one-hot
	typedef enum logic [2:0] {
		ST_FUSE_REQ  = 3'b001,
		ST_FUSE_WAIT = 3'b010,
		ST_RUN       = 3'b100
	} load_state_e;

	// current converter configuration
	typedef struct packed {
		logic single_mode;   // 1 = single channel, 0 = dual channel
		logic fg_cal_en;     // foreground calibration enabled
		logic second_input;  // 1 = second analog input, 0 = first
	} route_cfg_s;

	// trims routed to the cores
	typedef struct packed {
		logic        a_timing_vld;
		logic [7:0]  a_timing;
		logic        b_timing_vld;
		logic [7:0]  b_timing;
		logic        a_offset_vld;
		logic [11:0] a_offset;
	} trim_out_s;

	// whole state of the bank
	typedef struct packed {
		load_state_e      state;
		logic [2:0]       fuse_idx;
		logic             fuse_rd;
		logic [5:0][15:0] trim;
		logic [15:0]      rdata;
		trim_out_s        route;
	} bank_state_s;

endpackage

// ==== hw/adc_core_timing_offset_trim_bank.sv ====
// calibration trim register bank for converter cores a and b
// Function
// [RULE1] offset 0x315 timing trim drives core b: single mode, calibration on, first input.
// [RULE2] offset 0x31a timing trim drives core a: single mode, calibration on, second input.
// [RULE3] offset 0x31b timing trim drives core b: single mode, calibration on, second input.
// [RULE4] offset 0x344 12-bit offset trim drives core a: dual mode, calibration, first input.
// [RULE5] offset 0x346 12-bit offset trim drives core a: dual mode, calibration, second input.
// [RULE6] offset 0x348 offset trim drives core a in single mode on first input.
// [RULE7] offset registers keep bits 15:12 as read-write reserved, reset zero.
// [RULE8] after reset every trim is loaded with its factory value from fuse memory.
// [RULE9] timing trims shift sampling instant; software reads back and overwrites them.
// [RULE10] each core gets only the trims whose conditions match; others have no effect.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

`include "trim_bank_defines.svh"

module adc_core_timing_offset_trim_bank (
	// clock and reset
	input  wire logic                      REF_CLK,
	input  wire logic                      ARST_N,
	// register port
	input  wire logic [11:0]               ADDR,
	input  wire logic [15:0]               WDATA,
	input  wire logic                      WR,
	input  wire logic                      RD,
	output logic [15:0]                    RDATA,
	// fuse memory, data captured at the edge that ends the read strobe cycle
	output logic                           FUSE_RD,
	output logic [2:0]                     FUSE_ADDR,
	input  wire logic [15:0]               FUSE_DATA,
	output logic                           LOAD_DONE,
	// converter configuration and routed trims
	input  wire trim_bank_pkg::route_cfg_s CFG,
	output trim_bank_pkg::trim_out_s       TRIM
);
	import trim_bank_pkg::*;

	// ==========================================================
	// helpers
	// ==========================================================

	// one-hot slot select for a register address, zero when unmapped
	function automatic logic [5:0] slot_hit(input logic [11:0] a);
		logic [5:0] h;
		h = 6'h00;
		h[`IDX_B_SINGLE_IN1_TIMING] = (a == `OFS_CORE_B_SINGLE_IN1_TIMING_TRIM);
		h[`IDX_A_SINGLE_IN2_TIMING] = (a == `OFS_CORE_A_SINGLE_IN2_TIMING_TRIM);
		h[`IDX_B_SINGLE_IN2_TIMING] = (a == `OFS_CORE_B_SINGLE_IN2_TIMING_TRIM);
		h[`IDX_A_DUAL_IN1_OFFSET]   = (a == `OFS_CORE_A_DUAL_IN1_OFFSET_TRIM);
		h[`IDX_A_DUAL_IN2_OFFSET]   = (a == `OFS_CORE_A_DUAL_IN2_OFFSET_TRIM);
		h[`IDX_A_SINGLE_IN1_OFFSET] = (a == `OFS_CORE_A_SINGLE_IN1_OFFSET_TRIM);
		return h;
	endfunction

	// storable bits of a slot: timing slots hold 8 bits, offset slots all 16
	function automatic logic [15:0] slot_mask(input logic [2:0] idx);
		logic [15:0] m;
		m = (idx <= `IDX_B_SINGLE_IN2_TIMING) ? `TIMING_TRIM_MASK : `OFFSET_REG_MASK;
		return m;
	endfunction

	// ==========================================================
	// state
	// ==========================================================

	localparam bank_state_s RESET_STATE = '{
		state:    ST_FUSE_REQ,
		fuse_idx: 3'h0,
		fuse_rd:  1'b0,
		trim:     {`OFFSET_TRIM_RESET, `OFFSET_TRIM_RESET, `OFFSET_TRIM_RESET,
		           `TIMING_TRIM_RESET, `TIMING_TRIM_RESET, `TIMING_TRIM_RESET},
		rdata:    16'h0000,
		route:    '0
	};

	bank_state_s st_q;
	bank_state_s st_d;
	logic [5:0]  hit;
	logic        single;
	logic        dual;
	logic        in1;
	logic        in2;
	logic        fg;

	assign hit    = slot_hit(ADDR);
	assign single = CFG.single_mode;
	assign dual   = ~CFG.single_mode;
	assign in1    = ~CFG.second_input;
	assign in2    = CFG.second_input;
	assign fg     = CFG.fg_cal_en;

	// ==========================================================
	// next state
	// ==========================================================

	always_comb begin
		st_d         = st_q;
		st_d.fuse_rd = 1'b0;
		st_d.rdata   = 16'h0000;

		// fuse load sequence; software writes are dropped until it ends
		// so a half loaded bank never mixes user and factory values
		unique case (st_q.state)
			ST_FUSE_REQ: begin
				st_d.fuse_rd = 1'b1;
				st_d.state   = ST_FUSE_WAIT;
			end
			ST_FUSE_WAIT: begin
				st_d.trim[st_q.fuse_idx] = FUSE_DATA & slot_mask(st_q.fuse_idx); // RULE8 RULE7
				if (st_q.fuse_idx == `TRIM_LAST_IDX) begin
					st_d.state = ST_RUN;
				end else begin
					st_d.fuse_idx = st_q.fuse_idx + 3'h1;
					st_d.state    = ST_FUSE_REQ;
				end
			end
			ST_RUN: begin
				// software overwrite of the factory values
				if (WR) begin
					for (int i = 0; i < 6; i++) begin
						if (hit[i]) begin
							st_d.trim[i] = WDATA & slot_mask(3'(i)); // RULE9 RULE7
						end
					end
				end
			end
		endcase

		// read back, unmapped addresses answer zero
		if (RD) begin
			for (int i = 0; i < 6; i++) begin
				if (hit[i]) begin
					st_d.rdata = st_q.trim[i]; // RULE9
				end
			end
		end

		// routing: each output carries only the trim whose conditions hold now
		st_d.route = '0;
		if (single && fg && in2) begin
			st_d.route.a_timing_vld = 1'b1; // RULE2 RULE10
			st_d.route.a_timing     = st_q.trim[`IDX_A_SINGLE_IN2_TIMING][`TIMING_TRIM_MSB:0]; // RULE2
		end
		if (single && fg && in1) begin
			st_d.route.b_timing_vld = 1'b1; // RULE1 RULE10
			st_d.route.b_timing     = st_q.trim[`IDX_B_SINGLE_IN1_TIMING][`TIMING_TRIM_MSB:0]; // RULE1
		end else if (single && fg && in2) begin
			st_d.route.b_timing_vld = 1'b1; // RULE3 RULE10
			st_d.route.b_timing     = st_q.trim[`IDX_B_SINGLE_IN2_TIMING][`TIMING_TRIM_MSB:0]; // RULE3
		end
		// the reserved nibble never reaches the core
		if (dual && fg && in1) begin
			st_d.route.a_offset_vld = 1'b1; // RULE4 RULE10
			st_d.route.a_offset     = st_q.trim[`IDX_A_DUAL_IN1_OFFSET][`OFFSET_TRIM_MSB:0]; // RULE4
		end else if (dual && fg && in2) begin
			st_d.route.a_offset_vld = 1'b1; // RULE5 RULE10
			st_d.route.a_offset     = st_q.trim[`IDX_A_DUAL_IN2_OFFSET][`OFFSET_TRIM_MSB:0]; // RULE5
		end else if (single && in1) begin
			st_d.route.a_offset_vld = 1'b1; // RULE6 RULE10
			st_d.route.a_offset     = st_q.trim[`IDX_A_SINGLE_IN1_OFFSET][`OFFSET_TRIM_MSB:0]; // RULE6
		end
	end

	// ==========================================================
	// registers
	// ==========================================================

	// single state register; reset takes constants only
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q <= RESET_STATE;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from flip-flops, except LOAD_DONE, which is decoded from the state register
	assign RDATA     = st_q.rdata;
	assign FUSE_RD   = st_q.fuse_rd;
	assign FUSE_ADDR = st_q.fuse_idx;
	assign LOAD_DONE = (st_q.state == ST_RUN);
	assign TRIM      = st_q.route;

endmodule

// ==== verification/trim_bank_sva.sv ====
// assertion checker for the trim bank ports
`timescale 1ns/1ps
// ========================
// checker
module trim_bank_sva (
	// clock and reset
	input wire logic                       REF_CLK,
	input wire logic                       ARST_N,
	// register port
	input wire logic [11:0]                ADDR,
	input wire logic [15:0]                WDATA,
	input wire logic                       WR,
	input wire logic                       RD,
	input wire logic [15:0]                RDATA,
	// fuse load and routing
	input wire logic                       FUSE_RD,
	input wire logic                       LOAD_DONE,
	input wire trim_bank_pkg::route_cfg_s  CFG,
	input wire trim_bank_pkg::trim_out_s   TRIM
);
	import trim_bank_pkg::*;
	// one domain, so one clock and one reset serve all
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!ARST_N);
	// register port
	AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0) else $error("read data outside slot");
	AST_TIM_HI: assert property (RD && ADDR == 12'h31b |=> RDATA[15:8] == 8'h0) else $error("timing high byte");
	AST_RSVD: assert property (LOAD_DONE && WR && ADDR == 12'h346
		##1 RD && ADDR == 12'h346 |=> RDATA == $past(WDATA, 2)) else $error("offset readback wrong");
	// fuse load
	AST_FUSE_1: assert property (FUSE_RD |=> !FUSE_RD) else $error("fuse strobe too long");
	AST_DONE: assert property (LOAD_DONE |=> LOAD_DONE && !FUSE_RD) else $error("load restarted");
	// routing lags the configuration by one cycle; the first edge after reset is skipped
	AST_A_TIM: assert property ($past(ARST_N) |-> TRIM.a_timing_vld == $past(CFG == 3'b111))
		else $error("a timing select");
	AST_B_TIM: assert property ($past(ARST_N) |-> TRIM.b_timing_vld == $past(CFG.single_mode && CFG.fg_cal_en))
		else $error("b timing select");
	AST_A_OFS: assert property ($past(ARST_N) |-> TRIM.a_offset_vld ==
		$past(CFG.single_mode ? !CFG.second_input : CFG.fg_cal_en)) else $error("a offset select");
	AST_ZERO: assert property (!TRIM.b_timing_vld |-> TRIM.b_timing == 8'h0) else $error("unused trim leaks");
	// main scenarios
	cover property ($rose(LOAD_DONE));
	cover property (TRIM.a_timing_vld);
	cover property (TRIM.a_offset_vld && CFG.single_mode);
endmodule
bind adc_core_timing_offset_trim_bank trim_bank_sva chk (.REF_CLK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.FUSE_RD, .LOAD_DONE, .CFG, .TRIM);

// ==== verification/adc_core_timing_offset_trim_bank_bench.sv ====
// self-checking bench for the trim bank
`timescale 1ns/1ps
// ========================
// bench
module adc_core_timing_offset_trim_bank_bench;
	import trim_bank_pkg::*;
	logic        clk, arst_n, wr, rd, fuse_rd, load_done;
	logic [11:0] addr;
	logic [15:0] wdata, rdata, fuse_data;
	logic [2:0]  fuse_addr;
	route_cfg_s  cfg;
	trim_out_s   trim, exp_t;
	int          bad_count, compares;
	logic [15:0] fw [6] = '{16'h01a5, 16'h0b3c, 16'h7e5a, 16'h0123, 16'h0456, 16'h0789};
	logic [11:0] ofs [6] = '{12'h315, 12'h31a, 12'h31b, 12'h344, 12'h346, 12'h348};
	adc_core_timing_offset_trim_bank uut (.REF_CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .FUSE_RD(fuse_rd), .FUSE_ADDR(fuse_addr), .FUSE_DATA(fuse_data),
		.LOAD_DONE(load_done), .CFG(cfg), .TRIM(trim));
	// the bank captures the fuse word at the edge that ends its strobe cycle,
	// so the word stands while the strobe is high; inverted otherwise so a late capture shows
	always @* fuse_data = fuse_rd ? fw[fuse_addr] : ~fw[fuse_addr];
	// value written in the readback test; timing slots keep only the low byte
	function automatic logic [15:0] nv(int i);
		return (fw[i] ^ 16'hf0f0) & (i < 3 ? 16'h00ff : 16'hffff);
	endfunction
	task automatic chk(logic [30:0] e, logic [30:0] g, string n);
		compares++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	// strobes are set at the start, so operations run back to back
	task automatic reg_wr(logic [11:0] a, logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_rd(logic [11:0] a, logic [15:0] e);
		addr <= a;
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		// read data stand only in the cycle after the strobe
		#1 chk(31'(e), 31'(rdata), $sformatf("reg %h", a));
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// run is about 65 cycles; this cuts a hang short
	initial begin
		#20us;
		bad_count++;
		wrap_up();
	end
	initial begin
		{arst_n, wr, rd, addr, wdata, cfg} = '0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		reg_wr(12'h344, 16'h0fff);
		wr <= 1'b0;
		for (int i = 0; i < 30 && !load_done; i++) @(posedge clk);
		chk(31'(1), 31'(load_done), "load done");
		for (int i = 0; i < 6; i++) reg_rd(ofs[i], fw[i] & (i < 3 ? 16'h00ff : 16'hffff));
		$display("fuse load test done");
		for (int i = 0; i < 6; i++) begin
			reg_wr(ofs[i], fw[i] ^ 16'hf0f0);
			reg_rd(ofs[i], nv(i));
		end
		reg_wr(12'h316, 16'hffff);
		reg_rd(12'h316, 16'h0000);
		$display("readback test done");
		// all eight configurations, only matching trims may reach a core
		for (int c = 0; c < 8; c++) begin
			cfg <= route_cfg_s'(c[2:0]);
			repeat (2) @(posedge clk);
			#1 exp_t = '0;
			if (c[2] && c[1]) begin
				exp_t.b_timing_vld = 1'b1;
				exp_t.b_timing = 8'(nv(c[0] ? 2 : 0));
				exp_t.a_timing_vld = c[0];
				exp_t.a_timing = c[0] ? 8'(nv(1)) : 8'h0;
			end
			if (c[2] ? !c[0] : c[1]) begin
				exp_t.a_offset_vld = 1'b1;
				exp_t.a_offset = 12'(nv(c[2] ? 5 : (c[0] ? 4 : 3)));
			end
			chk(exp_t, trim, $sformatf("trims cfg %0d", c));
		end
		$display("routing test done");
		wrap_up();
	end
endmodule
